// ===== logic/lamp_adj_pkg.sv
// Constants and types for the status lamp and commutation adjust block
package lamp_adj_pkg;
    // Clock rate and documented times
    localparam longint unsigned CLK_HZ = 64'h0000_0000_0BEB_C200;
    localparam longint unsigned INIT_TIME_S = 64'h0000_0000_0000_0005;
    localparam longint unsigned CONN_TIME_S = 64'h0000_0000_0000_0014;
    localparam longint unsigned BLINK_HZ = 64'h0000_0000_0000_0002;
    localparam int unsigned CNT_W = 33;
    localparam logic [CNT_W-1:0] INIT_CYC = CNT_W'(INIT_TIME_S * CLK_HZ);
    localparam logic [CNT_W-1:0] CONN_CYC = CNT_W'(CONN_TIME_S * CLK_HZ);
    // Half of one blink period, rounded down
    localparam logic [CNT_W-1:0] BLINK_HALF_CYC = CNT_W'(CLK_HZ / (BLINK_HZ * 2));

    // Parameter numbers
    localparam logic [15:0] NUM_IDENTIFY = 16'h0090;
    localparam logic [15:0] NUM_TRIGGER = 16'h07C6;
    localparam logic [15:0] NUM_OFFSET = 16'h01AF;
    localparam logic [15:0] ENC_FIRST = 16'h0190;
    localparam logic [15:0] ENC_LAST = 16'h01F3;

    // Parameter values
    localparam logic [31:0] IDENT_ON = 32'h0000_0001;
    localparam logic [31:0] IDENT_OFF = 32'h0000_0000;
    localparam logic [31:0] TRIG_IDLE = 32'h0000_0000;
    localparam logic [31:0] TRIG_RUN = 32'h0000_0001;
    localparam logic [31:0] OFFSET_RST = 32'h0000_0000;

    typedef enum logic [2:0] {
        ACC_STANDARD,
        ACC_EXTENDED,
        ACC_EXPERT,
        ACC_SERVICE,
        ACC_MACRO
    } access_level_type;

    localparam access_level_type LVL_IDENTIFY = ACC_EXTENDED;
    localparam access_level_type LVL_TRIGGER = ACC_EXPERT;
    localparam access_level_type LVL_OFFSET = ACC_SERVICE;

    typedef enum logic [1:0] {PH_IDLE, PH_INIT, PH_CONNECT, PH_RUN} phase_type;

    typedef struct packed {
        logic green;
        logic red;
    } lamp_type;

    localparam lamp_type LAMP_OFF = '{green: 1'h0, red: 1'h0};
    localparam lamp_type LAMP_RED = '{green: 1'h0, red: 1'h1};
    localparam lamp_type LAMP_GREEN = '{green: 1'h1, red: 1'h0};
    localparam lamp_type LAMP_ORANGE = '{green: 1'h1, red: 1'h1};

    typedef struct packed {
        logic [15:0] num;
        logic [31:0] data;
        access_level_type level;
        logic password_ok;
        logic via_macro;
    } param_req_type;

    typedef struct packed {
        logic done;
        logic ok;
        logic denied;
        logic unknown;
    } param_resp_type;
endpackage : lamp_adj_pkg

// ===== logic/phase_timer.sv
// Down counter that pulses once a loaded number of cycles has elapsed
`timescale 1ns/100ps
module phase_timer #(
    parameter int unsigned W = lamp_adj_pkg::CNT_W
) (
    input logic ref_clk_in,
    input logic rstn_in,
    input logic load_in,
    input logic [W-1:0] count_in,
    output logic expire_out
);
    logic [W-1:0] cnt_r;
    logic active_r;

    // Load wins over a running count so a periodic user can reload on expiry
    always_ff @(posedge ref_clk_in)
    begin
        if (!rstn_in)
        begin
            cnt_r <= '0;
            active_r <= 1'b0;
        end
        else if (load_in)
        begin
            cnt_r <= count_in - 1'b1;
            active_r <= 1'b1;
        end
        else if (active_r)
        begin
            if (cnt_r == '0)
                active_r <= 1'b0;
            else
                cnt_r <= cnt_r - 1'b1;
        end
    end

    assign expire_out = active_r && (cnt_r == '0);
endmodule : phase_timer

// ===== logic/param_gate.sv
// Access level check and number decode for parameter writes
`timescale 1ns/100ps
module param_gate (
    input lamp_adj_pkg::param_req_type req_in,
    output logic known_out,
    output lamp_adj_pkg::access_level_type level_out,
    output logic granted_out
);
    logic in_enc;

    always_comb
    begin
        in_enc = (req_in.num >= lamp_adj_pkg::ENC_FIRST) &&
            (req_in.num <= lamp_adj_pkg::ENC_LAST);
        known_out = 1'b1;
        level_out = lamp_adj_pkg::ACC_STANDARD;
        unique case (req_in.num)
            lamp_adj_pkg::NUM_IDENTIFY: level_out = lamp_adj_pkg::LVL_IDENTIFY;
            lamp_adj_pkg::NUM_TRIGGER: level_out = lamp_adj_pkg::LVL_TRIGGER;
            lamp_adj_pkg::NUM_OFFSET:
            begin
                // Encoder parameters only answer inside their own range
                known_out = in_enc;
                level_out = lamp_adj_pkg::LVL_OFFSET;
            end
            default: known_out = 1'b0;
        endcase
        granted_out = known_out && (req_in.level >= level_out);
        if (level_out == lamp_adj_pkg::ACC_SERVICE)
            granted_out = granted_out && req_in.password_ok;
        if (level_out == lamp_adj_pkg::ACC_MACRO)
            granted_out = known_out && req_in.via_macro;
    end
endmodule : param_gate

// ===== logic/encoder_status_led_and_adjust.sv
// Ready lamp sequencing and commutation adjust handshake of the encoder
// What this block does
// - Red lamp about five seconds at start-up
// - Then orange about twenty seconds for link setup
// - Steady green in normal data exchange
// - Steady red on a measuring error in the running phase
// - Orange means green and red lit together
// - Identify set to one blinks at 2 Hz, in the running phase only
// - Adjust trigger returns to zero by itself
// - Stored offset loads into offset parameter automatically
// - Five access levels; service needs password, macro macro
// - Encoder parameters lie in 0400 to 0499
`timescale 1ns/100ps
module encoder_status_led_and_adjust #(
    parameter logic [lamp_adj_pkg::CNT_W-1:0] INIT_CYCLES = lamp_adj_pkg::INIT_CYC,
    parameter logic [lamp_adj_pkg::CNT_W-1:0] CONN_CYCLES = lamp_adj_pkg::CONN_CYC,
    parameter logic [lamp_adj_pkg::CNT_W-1:0] BLINK_CYCLES = lamp_adj_pkg::BLINK_HALF_CYC
) (
    input logic ref_clk_in,
    input logic rstn_in,
    input logic attached_in,
    input logic data_exchange_in,
    input logic meas_error_in,
    input logic param_req_valid_in,
    input lamp_adj_pkg::param_req_type param_req_in,
    input logic ident_done_in,
    input logic offset_stored_in,
    input logic [31:0] offset_calc_in,
    output lamp_adj_pkg::lamp_type lamp_out,
    output logic ident_start_out,
    output logic [31:0] identify_value_out,
    output logic [31:0] trigger_value_out,
    output logic [31:0] offset_value_out,
    output lamp_adj_pkg::param_resp_type param_resp_out
);
    localparam int unsigned W = lamp_adj_pkg::CNT_W;

    lamp_adj_pkg::phase_type ph_r;
    lamp_adj_pkg::phase_type ph_nxt;
    logic ph_load;
    logic [W-1:0] ph_count;
    logic ph_expire;

    logic blink_active;
    logic blink_active_r;
    logic blink_load;
    logic blink_expire;
    logic blink_phase_r;

    lamp_adj_pkg::lamp_type lamp_r;
    lamp_adj_pkg::lamp_type lamp_nxt;
    lamp_adj_pkg::lamp_type lamp_base;

    logic known;
    logic granted;
    lamp_adj_pkg::access_level_type level;
    logic wr_ok;
    logic trig_start;
    logic [31:0] identify_r;
    logic [31:0] trigger_r;
    logic [31:0] offset_r;
    logic ident_start_r;
    lamp_adj_pkg::param_resp_type param_resp_r;

    // Start-up phase sequencing; a lost attachment starts over
    always_comb
    begin
        ph_nxt = ph_r;
        ph_load = 1'b0;
        ph_count = INIT_CYCLES;
        unique case (ph_r)
            lamp_adj_pkg::PH_IDLE:
            begin
                if (attached_in)
                begin
                    ph_nxt = lamp_adj_pkg::PH_INIT;
                    ph_load = 1'b1;
                end
            end
            lamp_adj_pkg::PH_INIT:
            begin
                if (ph_expire)
                begin
                    ph_nxt = lamp_adj_pkg::PH_CONNECT;
                    ph_load = 1'b1;
                    ph_count = CONN_CYCLES;
                end
            end
            lamp_adj_pkg::PH_CONNECT:
            begin
                if (ph_expire)
                    ph_nxt = lamp_adj_pkg::PH_RUN;
            end
            lamp_adj_pkg::PH_RUN:
            begin
                ph_nxt = lamp_adj_pkg::PH_RUN;
            end
        endcase
        if (!attached_in)
        begin
            ph_nxt = lamp_adj_pkg::PH_IDLE;
            ph_load = 1'b0;
        end
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (!rstn_in)
            ph_r <= lamp_adj_pkg::PH_IDLE;
        else
            ph_r <= ph_nxt;
    end

    phase_timer #(.W(W)) u_phase_timer (
        .ref_clk_in(ref_clk_in),
        .rstn_in(rstn_in),
        .load_in(ph_load),
        .count_in(ph_count),
        .expire_out(ph_expire)
    );

    // Identification blink, only once the link is in normal running
    assign blink_active = (ph_r == lamp_adj_pkg::PH_RUN) &&
        (identify_r == lamp_adj_pkg::IDENT_ON);
    assign blink_load = blink_active && (!blink_active_r || blink_expire);

    always_ff @(posedge ref_clk_in)
    begin
        if (!rstn_in)
        begin
            blink_active_r <= 1'b0;
            blink_phase_r <= 1'b0;
        end
        else
        begin
            blink_active_r <= blink_active;
            if (!blink_active)
                blink_phase_r <= 1'b0;
            else if (blink_expire && blink_active_r)
                blink_phase_r <= !blink_phase_r;
        end
    end

    phase_timer #(.W(W)) u_blink_timer (
        .ref_clk_in(ref_clk_in),
        .rstn_in(rstn_in),
        .load_in(blink_load),
        .count_in(BLINK_CYCLES),
        .expire_out(blink_expire)
    );

    // Lamp colour; error outranks data exchange
    always_comb
    begin
        if (meas_error_in)
            lamp_base = lamp_adj_pkg::LAMP_RED;
        else if (data_exchange_in)
            lamp_base = lamp_adj_pkg::LAMP_GREEN;
        else
            lamp_base = lamp_adj_pkg::LAMP_ORANGE;
        unique case (ph_r)
            lamp_adj_pkg::PH_IDLE: lamp_nxt = lamp_adj_pkg::LAMP_OFF;
            lamp_adj_pkg::PH_INIT: lamp_nxt = lamp_adj_pkg::LAMP_RED;
            lamp_adj_pkg::PH_CONNECT: lamp_nxt = lamp_adj_pkg::LAMP_ORANGE;
            lamp_adj_pkg::PH_RUN:
            begin
                if (blink_active && blink_phase_r)
                    lamp_nxt = lamp_adj_pkg::LAMP_ORANGE;
                else
                    lamp_nxt = lamp_base;
            end
        endcase
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (!rstn_in)
            lamp_r <= lamp_adj_pkg::LAMP_OFF;
        else
            lamp_r <= lamp_nxt;
    end

    param_gate u_param_gate (
        .req_in(param_req_in),
        .known_out(known),
        .level_out(level),
        .granted_out(granted)
    );

    assign wr_ok = param_req_valid_in && granted;
    // Only a 0 to 1 change starts the procedure; writes while busy are ignored
    assign trig_start = wr_ok && (param_req_in.num == lamp_adj_pkg::NUM_TRIGGER) &&
        (trigger_r == lamp_adj_pkg::TRIG_IDLE) &&
        (param_req_in.data == lamp_adj_pkg::TRIG_RUN);

    always_ff @(posedge ref_clk_in)
    begin
        if (!rstn_in)
            identify_r <= lamp_adj_pkg::IDENT_OFF;
        else if (wr_ok && (param_req_in.num == lamp_adj_pkg::NUM_IDENTIFY))
            identify_r <= param_req_in.data;
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (!rstn_in)
        begin
            trigger_r <= lamp_adj_pkg::TRIG_IDLE;
            ident_start_r <= 1'b0;
        end
        else
        begin
            ident_start_r <= trig_start;
            if (trig_start)
                trigger_r <= lamp_adj_pkg::TRIG_RUN;
            else if (ident_done_in)
                trigger_r <= lamp_adj_pkg::TRIG_IDLE;
        end
    end

    // The stored result wins over a write in the same cycle
    always_ff @(posedge ref_clk_in)
    begin
        if (!rstn_in)
            offset_r <= lamp_adj_pkg::OFFSET_RST;
        else if (offset_stored_in)
            offset_r <= offset_calc_in;
        else if (wr_ok && (param_req_in.num == lamp_adj_pkg::NUM_OFFSET))
            offset_r <= param_req_in.data;
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (!rstn_in)
            param_resp_r <= '0;
        else
        begin
            param_resp_r.done <= param_req_valid_in;
            param_resp_r.ok <= wr_ok;
            param_resp_r.denied <= param_req_valid_in && known && !granted;
            param_resp_r.unknown <= param_req_valid_in && !known;
        end
    end

    assign lamp_out = lamp_r;
    assign ident_start_out = ident_start_r;
    assign identify_value_out = identify_r;
    assign trigger_value_out = trigger_r;
    assign offset_value_out = offset_r;
    assign param_resp_out = param_resp_r;

    // Helper counters read only by the checks below
    logic [W-1:0] ph_cycles_r;
    logic [W-1:0] blink_cycles_r;

    always_ff @(posedge ref_clk_in)
    begin
        if (!rstn_in || (ph_nxt != ph_r))
            ph_cycles_r <= '0;
        else
            ph_cycles_r <= ph_cycles_r + 1'b1;
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (!rstn_in || blink_load)
            blink_cycles_r <= '0;
        else
            blink_cycles_r <= blink_cycles_r + 1'b1;
    end

    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (!rstn_in);

    property p_init_len;
        (ph_r == lamp_adj_pkg::PH_CONNECT) && ($past(ph_r) == lamp_adj_pkg::PH_INIT)
            |-> $past(ph_cycles_r) == INIT_CYCLES - 1'b1;
    endproperty
    a_init_len: assert property (p_init_len) else $error("init phase length wrong");

    property p_init_red;
        (ph_r == lamp_adj_pkg::PH_INIT) |=> (lamp_r == lamp_adj_pkg::LAMP_RED);
    endproperty
    a_init_red: assert property (p_init_red) else $error("lamp not red in init");

    property p_conn_len;
        (ph_r == lamp_adj_pkg::PH_RUN) && ($past(ph_r) == lamp_adj_pkg::PH_CONNECT)
            |-> $past(ph_cycles_r) == CONN_CYCLES - 1'b1;
    endproperty
    a_conn_len: assert property (p_conn_len) else $error("connect phase length wrong");

    property p_conn_orange;
        (ph_r == lamp_adj_pkg::PH_CONNECT) |=> lamp_r.green && lamp_r.red;
    endproperty
    a_conn_orange: assert property (p_conn_orange) else $error("connect not orange");

    property p_run_green;
        (ph_r == lamp_adj_pkg::PH_RUN) && data_exchange_in && !meas_error_in && !blink_active
            |=> (lamp_r == lamp_adj_pkg::LAMP_GREEN);
    endproperty
    a_run_green: assert property (p_run_green) else $error("run lamp not green");

    property p_err_red;
        (ph_r == lamp_adj_pkg::PH_RUN) && meas_error_in && !blink_phase_r
            |=> (lamp_r == lamp_adj_pkg::LAMP_RED);
    endproperty
    a_err_red: assert property (p_err_red) else $error("error lamp not red");

    property p_blink_half;
        blink_expire && blink_active_r |-> blink_cycles_r == BLINK_CYCLES - 1'b1 ##1
            (blink_phase_r != $past(blink_phase_r, 2)) || !blink_active_r;
    endproperty
    a_blink_half: assert property (p_blink_half) else $error("blink half period wrong");

    property p_blink_orange;
        blink_active && blink_phase_r |=> (lamp_r == lamp_adj_pkg::LAMP_ORANGE);
    endproperty
    a_blink_orange: assert property (p_blink_orange) else $error("blink not orange");

    property p_trig_start;
        trig_start |=> ident_start_r && (trigger_r == lamp_adj_pkg::TRIG_RUN) ##1 !ident_start_r;
    endproperty
    a_trig_start: assert property (p_trig_start) else $error("trigger start wrong");

    property p_trig_clear;
        ident_done_in && (trigger_r == lamp_adj_pkg::TRIG_RUN)
            |=> (trigger_r == lamp_adj_pkg::TRIG_IDLE);
    endproperty
    a_trig_clear: assert property (p_trig_clear) else $error("trigger did not clear");

    property p_offset_load;
        offset_stored_in |=> offset_r == $past(offset_calc_in);
    endproperty
    a_offset_load: assert property (p_offset_load) else $error("offset not loaded");

    property p_service_pw;
        param_req_valid_in && known && (level == lamp_adj_pkg::ACC_SERVICE) &&
            !param_req_in.password_ok |=> param_resp_r.denied && !param_resp_r.ok;
    endproperty
    a_service_pw: assert property (p_service_pw) else $error("service write without password");

    property p_enc_range;
        param_req_valid_in && (param_req_in.num != lamp_adj_pkg::NUM_OFFSET) &&
            (param_req_in.num >= lamp_adj_pkg::ENC_FIRST) &&
            (param_req_in.num <= lamp_adj_pkg::ENC_LAST) |=> param_resp_r.unknown;
    endproperty
    a_enc_range: assert property (p_enc_range) else $error("unknown encoder number taken");

    c_reach_run: cover property ((ph_r == lamp_adj_pkg::PH_RUN) && data_exchange_in);
    c_blink: cover property (blink_active && blink_expire);
    c_trig_cycle: cover property (trig_start ##[1:20] ident_done_in);
    c_offset: cover property (offset_stored_in);
endmodule : encoder_status_led_and_adjust

// ===== test/drive_ctrl_model.sv
// Behavioural drive control unit: parameter writes and pole position identification
`timescale 1ns/100ps
module drive_ctrl_model #(
    parameter logic [31:0] OFFSET_FOUND = 32'h0000_1234
) (
    input logic ref_clk_in,
    input logic ident_start_in,
    input lamp_adj_pkg::param_resp_type param_resp_in,
    output logic param_req_valid_out,
    output lamp_adj_pkg::param_req_type param_req_out,
    output logic ident_done_out,
    output logic offset_stored_out,
    output logic [31:0] offset_calc_out
);
    // Cycles from the start pulse to the end of identification; the bench varies it
    int done_delay = 8;

    initial
    begin
        param_req_valid_out = 1'b0;
        param_req_out = '0;
        ident_done_out = 1'b0;
        offset_stored_out = 1'b0;
        offset_calc_out = ~OFFSET_FOUND;
    end

    // An edge passes first so back-to-back calls never drop and raise valid at once;
    // held until the taking edge, the answer stands in the following cycle
    task automatic write_param(input lamp_adj_pkg::param_req_type req,
                               output lamp_adj_pkg::param_resp_type resp);
        @(posedge ref_clk_in);
        #1;
        param_req_out = req;
        param_req_valid_out = 1'b1;
        @(posedge ref_clk_in);
        #1;
        param_req_valid_out = 1'b0;
        param_req_out = ~req;
        resp = param_resp_in;
    endtask : write_param

    // Only issued while the trigger is idle, so the write is a change from 0 to 1
    task automatic start_adjust(output lamp_adj_pkg::param_resp_type resp);
        write_param('{lamp_adj_pkg::NUM_TRIGGER, lamp_adj_pkg::TRIG_RUN,
                      lamp_adj_pkg::ACC_EXPERT, 1'b0, 1'b0}, resp);
    endtask : start_adjust

    // Done first, the stored offset one cycle later; the value is garbage outside its pulse
    always @(posedge ref_clk_in)
    begin
        if (ident_start_in === 1'b1)
        begin
            repeat (done_delay) @(posedge ref_clk_in);
            #1;
            ident_done_out = 1'b1;
            @(posedge ref_clk_in);
            #1;
            ident_done_out = 1'b0;
            offset_stored_out = 1'b1;
            offset_calc_out = OFFSET_FOUND;
            @(posedge ref_clk_in);
            #1;
            offset_stored_out = 1'b0;
            offset_calc_out = ~OFFSET_FOUND;
        end
    end
endmodule : drive_ctrl_model

// ===== test/encoder_status_led_and_adjust_tb.sv
// Self-checking bench for the status lamp and commutation adjust block
`timescale 1ns/100ps
module encoder_status_led_and_adjust_tb;
    localparam int INIT_N = 32'h0000_0014;
    localparam int CONN_N = 32'h0000_0028;
    localparam int BLINK_N = 32'h0000_0006;
    localparam int LIMIT = 32'h0000_0BB8;
    localparam logic [3:0] R_OK = 4'hC;
    localparam logic [3:0] R_DEN = 4'hA;
    localparam logic [3:0] R_UNK = 4'h9;
    localparam logic [31:0] OFFS = 32'h0000_1234;

    typedef struct packed {
        lamp_adj_pkg::param_req_type req;
        logic [3:0] resp;
    } row_type;

    localparam row_type ROWS [10] = '{
        '{'{16'h0090, 32'h0000_0000, lamp_adj_pkg::ACC_STANDARD, 1'b0, 1'b0}, R_DEN},
        '{'{16'h0090, 32'h0000_0000, lamp_adj_pkg::ACC_EXTENDED, 1'b0, 1'b0}, R_OK},
        '{'{16'h07C6, 32'h0000_0001, lamp_adj_pkg::ACC_EXTENDED, 1'b0, 1'b0}, R_DEN},
        '{'{16'h01AF, 32'h0000_0005, lamp_adj_pkg::ACC_SERVICE, 1'b0, 1'b0}, R_DEN},
        '{'{16'h01AF, 32'h0000_0007, lamp_adj_pkg::ACC_MACRO, 1'b0, 1'b0}, R_DEN},
        '{'{16'h01AF, 32'h0000_0005, lamp_adj_pkg::ACC_SERVICE, 1'b1, 1'b0}, R_OK},
        '{'{16'h0190, 32'h0000_0001, lamp_adj_pkg::ACC_EXPERT, 1'b0, 1'b0}, R_UNK},
        '{'{16'h01F3, 32'h0000_0001, lamp_adj_pkg::ACC_EXPERT, 1'b0, 1'b0}, R_UNK},
        '{'{16'h01F4, 32'h0000_0001, lamp_adj_pkg::ACC_EXPERT, 1'b0, 1'b0}, R_UNK},
        '{'{16'h07C6, 32'h0000_0000, lamp_adj_pkg::ACC_EXPERT, 1'b0, 1'b0}, R_OK}
    };

    logic ref_clk_in;
    logic rstn_in;
    logic attached_in;
    logic data_exchange_in;
    logic meas_error_in;
    logic req_valid;
    lamp_adj_pkg::param_req_type req;
    logic ident_done;
    logic offset_stored;
    logic [31:0] offset_calc;
    lamp_adj_pkg::lamp_type lamp_out;
    logic ident_start_out;
    logic [31:0] identify_value_out;
    logic [31:0] trigger_value_out;
    logic [31:0] offset_value_out;
    lamp_adj_pkg::param_resp_type param_resp_out;
    int failures = 0;
    int comparisons = 0;
    int cycles = 0;

    encoder_status_led_and_adjust #(
        .INIT_CYCLES(lamp_adj_pkg::CNT_W'(INIT_N)),
        .CONN_CYCLES(lamp_adj_pkg::CNT_W'(CONN_N)),
        .BLINK_CYCLES(lamp_adj_pkg::CNT_W'(BLINK_N))
    ) dut (
        .ref_clk_in(ref_clk_in),
        .rstn_in(rstn_in),
        .attached_in(attached_in),
        .data_exchange_in(data_exchange_in),
        .meas_error_in(meas_error_in),
        .param_req_valid_in(req_valid),
        .param_req_in(req),
        .ident_done_in(ident_done),
        .offset_stored_in(offset_stored),
        .offset_calc_in(offset_calc),
        .lamp_out(lamp_out),
        .ident_start_out(ident_start_out),
        .identify_value_out(identify_value_out),
        .trigger_value_out(trigger_value_out),
        .offset_value_out(offset_value_out),
        .param_resp_out(param_resp_out)
    );

    drive_ctrl_model #(
        .OFFSET_FOUND(OFFS)
    ) drive (
        .ref_clk_in(ref_clk_in),
        .ident_start_in(ident_start_out),
        .param_resp_in(param_resp_out),
        .param_req_valid_out(req_valid),
        .param_req_out(req),
        .ident_done_out(ident_done),
        .offset_stored_out(offset_stored),
        .offset_calc_out(offset_calc)
    );

    initial
    begin
        ref_clk_in = 1'b0;
        forever #2.5 ref_clk_in = ~ref_clk_in;
    end

    task automatic tally_and_finish;
        $display("Comparisons %0d, mismatches %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : tally_and_finish

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            failures++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic check_lamp(input lamp_adj_pkg::lamp_type exp);
        check("lamp", 32'(lamp_out), 32'(exp));
    endtask : check_lamp

    // Inputs always move one nanosecond after the edge, outputs are settled by then
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge ref_clk_in);
        #1;
    endtask : wait_cyc

    // Any window of two whole blink periods shows the second colour for exactly half
    task automatic check_blink;
        int n;
        n = 0;
        for (int k = 0; k < 4 * BLINK_N; k++)
        begin
            wait_cyc(1);
            if (lamp_out === lamp_adj_pkg::LAMP_ORANGE)
                n++;
        end
        check("orange_cycles", 32'(n), 32'(2 * BLINK_N));
    endtask : check_blink

    always @(posedge ref_clk_in)
    begin
        cycles++;
        if (cycles == LIMIT)
        begin
            failures++;
            tally_and_finish();
        end
    end

    initial
    begin
        lamp_adj_pkg::param_resp_type resp;
        rstn_in = 1'b0;
        attached_in = 1'b0;
        data_exchange_in = 1'b0;
        meas_error_in = 1'b0;
        wait_cyc(5);
        rstn_in = 1'b1;
        check_lamp(lamp_adj_pkg::LAMP_OFF);
        check("trigger", trigger_value_out, lamp_adj_pkg::TRIG_IDLE);
        for (int i = 0; i < 10; i++)
        begin
            drive.write_param(ROWS[i].req, resp);
            check("param_resp", 32'(resp), 32'(ROWS[i].resp));
        end
        check("offset", offset_value_out, 32'h0000_0005);
        check("trigger", trigger_value_out, lamp_adj_pkg::TRIG_IDLE);
        attached_in = 1'b1;
        data_exchange_in = 1'b1;
        wait_cyc(2);
        check_lamp(lamp_adj_pkg::LAMP_RED);
        // Last cycle of each phase and first cycle of the next
        wait_cyc(INIT_N - 1);
        check_lamp(lamp_adj_pkg::LAMP_RED);
        wait_cyc(1);
        check_lamp(lamp_adj_pkg::LAMP_ORANGE);
        wait_cyc(CONN_N - 1);
        check_lamp(lamp_adj_pkg::LAMP_ORANGE);
        wait_cyc(1);
        check_lamp(lamp_adj_pkg::LAMP_GREEN);
        for (int i = 0; i < 4; i++)
        begin
            {meas_error_in, data_exchange_in} = 2'(i);
            wait_cyc(3);
            check_lamp(i[1] ? lamp_adj_pkg::LAMP_RED : (i[0] ? lamp_adj_pkg::LAMP_GREEN
                : lamp_adj_pkg::LAMP_ORANGE));
        end
        meas_error_in = 1'b0;
        drive.write_param('{lamp_adj_pkg::NUM_IDENTIFY, lamp_adj_pkg::IDENT_ON,
                            lamp_adj_pkg::ACC_EXTENDED, 1'b0, 1'b0}, resp);
        check("identify", identify_value_out, lamp_adj_pkg::IDENT_ON);
        wait_cyc(2 * BLINK_N + 2);
        check_blink();
        meas_error_in = 1'b1;
        wait_cyc(3);
        check_blink();
        drive.write_param('{lamp_adj_pkg::NUM_IDENTIFY, lamp_adj_pkg::IDENT_OFF,
                            lamp_adj_pkg::ACC_EXTENDED, 1'b0, 1'b0}, resp);
        wait_cyc(BLINK_N + 2);
        check_lamp(lamp_adj_pkg::LAMP_RED);
        meas_error_in = 1'b0;
        // Slow answer first, then a prompt one
        for (int d = 8; d > 0; d = d - 7)
        begin
            drive.done_delay = d;
            drive.start_adjust(resp);
            check("adj_resp", 32'(resp), 32'(R_OK));
            check("trigger", trigger_value_out, lamp_adj_pkg::TRIG_RUN);
            check("start", 32'(ident_start_out), 32'h0000_0001);
            drive.write_param('{lamp_adj_pkg::NUM_TRIGGER, lamp_adj_pkg::TRIG_RUN,
                                lamp_adj_pkg::ACC_EXPERT, 1'b0, 1'b0}, resp);
            check("start", 32'(ident_start_out), 32'h0000_0000);
            for (int k = 0; k < 40 && trigger_value_out !== lamp_adj_pkg::TRIG_IDLE; k++)
                wait_cyc(1);
            check("trigger", trigger_value_out, lamp_adj_pkg::TRIG_IDLE);
            wait_cyc(3);
            check("offset", offset_value_out, OFFS);
            drive.write_param('{lamp_adj_pkg::NUM_OFFSET, 32'h0000_0000,
                                lamp_adj_pkg::ACC_SERVICE, 1'b1, 1'b0}, resp);
        end
        attached_in = 1'b0;
        wait_cyc(3);
        check_lamp(lamp_adj_pkg::LAMP_OFF);
        attached_in = 1'b1;
        wait_cyc(3);
        check_lamp(lamp_adj_pkg::LAMP_RED);
        // Identify set on again so the reset value below is really observed
        drive.write_param('{lamp_adj_pkg::NUM_IDENTIFY, lamp_adj_pkg::IDENT_ON,
                            lamp_adj_pkg::ACC_EXTENDED, 1'b0, 1'b0}, resp);
        check("identify", identify_value_out, lamp_adj_pkg::IDENT_ON);
        rstn_in = 1'b0;
        wait_cyc(2);
        check_lamp(lamp_adj_pkg::LAMP_OFF);
        check("identify", identify_value_out, lamp_adj_pkg::IDENT_OFF);
        rstn_in = 1'b1;
        wait_cyc(3);
        check_lamp(lamp_adj_pkg::LAMP_RED);
        tally_and_finish();
    end
endmodule : encoder_status_led_and_adjust_tb
